/* hdl/usb_ctl_pkg.sv */
// Contract
// R1: Activity pending reads 1 while suspend must wait; meaningful only with sleep guard set.
// R2: Software sets sleep guard before suspend, then checks activity pending.
// R3: Suspend enable gates the USB clock and idles the transceiver; hardware may clear it.
// R4: Software clears power enable only after host, attach and OTG enables are zero.
// R5: Each completed transfer records its endpoint number 0..15 in status.
// R6: Last direction bit is 1 for transmit, 0 for receive.
// R7: Bank bit is 1 for odd bank, 0 for even bank.
// R8: Live single-ended zero flag readable in both modes.
// R9: Packet disable halts processing in device mode; set by SETUP, cleared by software.
// R10: Host enable turns on host capability and both data line pull-downs.
// R11: Attach enable in device mode enables module and D+ pull-up; clear detaches. Here module_enable follows only power enable.
// R12: Ping-pong reset forces all buffer pointers to the even bank.
// R13: Resume signaling is driven while resume bit is set; host holds it 10 ms.
// R14: Host mode live J state flag, polarity chosen by speed.
// R15: Token busy reads 1 while a host token executes.
// R16: Host bus reset driven while reset bit set; software holds it 50 ms.
// R17: Frame start enable sends a Start-Of-Frame token every 1 ms in host mode.
// R18: Speed select picks low speed when 1 in host mode; reads 0 in device mode.
// R19: Seven-bit device address held in the low bits of the address register.
// R20: Token types: SETUP 1101, IN 1001, OUT 0001; no other code.
// R21: Software writes only an existing endpoint number into the token endpoint.
// R22: Upper byte and unimplemented bits read 0 and ignore writes. OTG control bits 0, 1 and 3 are stored and read back as written.
// R23: OTG enable hands pulls to software bits; otherwise host and attach enables drive them.
// R24: Token register write in host mode launches one transaction; busy until done.
package usb_ctl_pkg;
	localparam int unsigned   ADDR_W            = 4;
	localparam int unsigned   DATA_W            = 16;
	localparam logic [3:0]    OFS_POWER         = 4'h0;
	localparam logic [3:0]    OFS_STATUS        = 4'h2;
	localparam logic [3:0]    OFS_CONTROL       = 4'h4;
	localparam logic [3:0]    OFS_DEV_ADDR      = 4'h6;
	localparam logic [3:0]    OFS_TOKEN         = 4'h8;
	localparam logic [3:0]    OFS_OTG_CTRL      = 4'ha;
	localparam int unsigned   PWR_EN_BIT        = 0;
	localparam int unsigned   SUSPEND_BIT       = 1;
	localparam int unsigned   GUARD_BIT         = 4;
	localparam int unsigned   ACT_PEND_BIT      = 7;
	localparam int unsigned   STAT_BANK_BIT     = 2;
	localparam int unsigned   STAT_DIR_BIT      = 3;
	localparam int unsigned   STAT_EP_LSB       = 4;
	localparam int unsigned   CON_BIT0          = 0;
	localparam int unsigned   CON_PPRST_BIT     = 1;
	localparam int unsigned   CON_RESUME_BIT    = 2;
	localparam int unsigned   CON_HOST_BIT      = 3;
	localparam int unsigned   CON_BUSRST_BIT    = 4;
	localparam int unsigned   CON_BIT5          = 5;
	localparam int unsigned   CON_SE0_BIT       = 6;
	localparam int unsigned   CON_J_STATE_LIVE_BIT    = 7;
	localparam int unsigned   ADDR_LS_BIT       = 7;
	localparam int unsigned   TOK_PID_LSB       = 4;
	localparam int unsigned   OTG_EN_BIT        = 2;
	localparam int unsigned   OTG_DMPD_BIT      = 4;
	localparam int unsigned   OTG_DPPD_BIT      = 5;
	localparam int unsigned   OTG_DMPU_BIT      = 6;
	localparam int unsigned   OTG_DPPU_BIT      = 7;
	localparam logic [3:0]    PID_SETUP         = 4'hd;
	localparam logic [3:0]    PID_IN            = 4'h9;
	localparam logic [3:0]    PID_OUT           = 4'h1;
	localparam logic [15:0]   REG_RESET         = 16'h0000;
	localparam int unsigned   CLK_PERIOD_NS     = 10;
	localparam int unsigned   SOF_PERIOD_NS     = 1000000;
	localparam int unsigned   SOF_CYCLES        = SOF_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned   SOF_CNT_W         = 17;

	typedef enum logic [1:0] {
		TOK_IDLE = 2'b01,
		TOK_RUN  = 2'b10
	} tok_state_e;
endpackage : usb_ctl_pkg

/* hdl/usb_core_ctl.sv */
`timescale 1ns/100ps
`default_nettype none
module usb_core_ctl
	import usb_ctl_pkg::*;
#(
	parameter int unsigned SOF_CYCLES_P = SOF_CYCLES
) (
	input  wire logic              clock,
	input  wire logic              rst_b,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata,
	input  wire logic              line_dp,
	input  wire logic              line_dm,
	input  wire logic              sie_busy,
	input  wire logic              wake_event,
	input  wire logic              setup_rx,
	input  wire logic              xfer_done,
	input  wire logic [3:0]        xfer_ep,
	input  wire logic              xfer_tx,
	input  wire logic              xfer_odd,
	input  wire logic              token_done,
	output logic                   module_enable,
	output logic                   usb_clock_run,
	output logic                   xcvr_low_power,
	output logic                   packet_proc_enable,
	output logic                   ping_pong_reset,
	output logic                   resume_drive,
	output logic                   bus_reset_drive,
	output logic                   low_speed_select,
	output logic                   dp_pullup,
	output logic                   dm_pullup,
	output logic                   dp_pulldown,
	output logic                   dm_pulldown,
	output logic                   sof_send,
	output logic                   token_launch,
	output logic      [3:0]        token_pid,
	output logic      [3:0]        token_endpoint,
	output logic      [6:0]        device_address
);

	logic                 power_q;
	logic                 suspend_q;
	logic                 guard_q;
	logic                 act_pend_q;
	logic [3:0]           stat_ep_q;
	logic                 stat_dir_q;
	logic                 stat_bank_q;
	logic                 con_bit0_q;
	logic                 pp_rst_q;
	logic                 resume_q;
	logic                 host_q;
	logic                 bus_rst_q;
	logic                 pkt_dis_q;
	logic                 ls_q;
	logic [6:0]           addr_q;
	logic [3:0]           tok_pid_q;
	logic [3:0]           tok_ep_q;
	logic [7:0]           otg_q;
	logic [1:0]           dp_sync_q;
	logic [1:0]           dm_sync_q;
	logic [SOF_CNT_W-1:0] sof_cnt_q;
	logic                 sof_q;
	logic                 launch_q;
	logic [DATA_W-1:0]    rdata_q;
	tok_state_e           tok_q;
	logic                 token_busy;
	logic                 se0_live;
	logic                 j_live;
	logic                 sof_run;
	logic                 tok_start;
	logic [DATA_W-1:0]    rd_mux;

	function automatic logic wr_hit(input logic [ADDR_W-1:0] ofs);
		return reg_wr && (reg_addr == ofs);
	endfunction : wr_hit

	function automatic logic pid_legal(input logic [3:0] pid);
		return (pid == PID_SETUP) || (pid == PID_IN) || (pid == PID_OUT);
	endfunction : pid_legal

	// Line pins cross into the clock domain
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			dp_sync_q <= 2'h0;
			dm_sync_q <= 2'h0;
		end else begin
			dp_sync_q <= {dp_sync_q[0], line_dp};
			dm_sync_q <= {dm_sync_q[0], line_dm};
		end
	end

	// R8: live SE0
	assign se0_live = !dp_sync_q[1] && !dm_sync_q[1];
	// R14: J polarity by speed
	assign j_live = ls_q ? (!dp_sync_q[1] && dm_sync_q[1]) : (dp_sync_q[1] && !dm_sync_q[1]);

	// R4: module power bit
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			power_q <= 1'b0;
			guard_q <= 1'b0;
		end else if (wr_hit(OFS_POWER)) begin
			power_q <= reg_wdata[PWR_EN_BIT];
			guard_q <= reg_wdata[GUARD_BIT];
		end
	end

	// R3: suspend, cleared by wake
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			suspend_q <= 1'b0;
		end else if (wr_hit(OFS_POWER)) begin
			suspend_q <= reg_wdata[SUSPEND_BIT];
		end else if (wake_event) begin
			suspend_q <= 1'b0;
		end
	end

	// R1: activity pending
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			act_pend_q <= 1'b0;
		end else begin
			act_pend_q <= guard_q && (sie_busy || token_busy);
		end
	end

	// R5: last endpoint capture
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			stat_ep_q   <= 4'h0;
			stat_dir_q  <= 1'b0;
			stat_bank_q <= 1'b0;
		end else if (xfer_done) begin
			stat_ep_q   <= xfer_ep;
			// R6: direction
			stat_dir_q  <= xfer_tx;
			// R7: bank
			stat_bank_q <= xfer_odd;
		end
	end

	// Control register writes
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			con_bit0_q <= 1'b0;
			pp_rst_q   <= 1'b0;
			resume_q   <= 1'b0;
			host_q     <= 1'b0;
			bus_rst_q  <= 1'b0;
		end else if (wr_hit(OFS_CONTROL)) begin
			con_bit0_q <= reg_wdata[CON_BIT0];
			pp_rst_q   <= reg_wdata[CON_PPRST_BIT];
			resume_q   <= reg_wdata[CON_RESUME_BIT];
			host_q     <= reg_wdata[CON_HOST_BIT];
			// R22: reset bit absent in device mode
			bus_rst_q  <= reg_wdata[CON_BUSRST_BIT] && reg_wdata[CON_HOST_BIT];
		end
	end

	// R9: SETUP sets, software clears
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pkt_dis_q <= 1'b0;
		end else if (setup_rx && !host_q) begin
			pkt_dis_q <= 1'b1;
		end else if (wr_hit(OFS_CONTROL) && !host_q) begin
			pkt_dis_q <= reg_wdata[CON_BIT5];
		end
	end

	// R19: address and speed
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			addr_q <= 7'h00;
			ls_q   <= 1'b0;
		end else if (wr_hit(OFS_DEV_ADDR)) begin
			addr_q <= reg_wdata[6:0];
			ls_q   <= reg_wdata[ADDR_LS_BIT];
		end
	end

	// R23: software pull controls
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			otg_q <= 8'h00;
		end else if (wr_hit(OFS_OTG_CTRL)) begin
			otg_q <= reg_wdata[7:0];
		end
	end

	// R24: token launch
	assign tok_start  = wr_hit(OFS_TOKEN) && host_q && (tok_q == TOK_IDLE)
	                    && pid_legal(reg_wdata[7:4]);
	assign token_busy = (tok_q == TOK_RUN);

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			tok_pid_q <= 4'h0;
			tok_ep_q  <= 4'h0;
		end else if (wr_hit(OFS_TOKEN) && (tok_q == TOK_IDLE)) begin
			tok_pid_q <= reg_wdata[7:4];
			// R21: endpoint as written
			tok_ep_q  <= reg_wdata[3:0];
		end
	end

	// R15: busy until done
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			tok_q    <= TOK_IDLE;
			launch_q <= 1'b0;
		end else begin
			launch_q <= tok_start;
			unique case (tok_q)
				TOK_IDLE: begin
					if (tok_start) begin
						tok_q <= TOK_RUN;
					end
				end
				TOK_RUN: begin
					if (token_done || !host_q) begin
						tok_q <= TOK_IDLE;
					end
				end
				default: begin
					tok_q <= TOK_IDLE;
				end
			endcase
		end
	end

	// R17: frame timer
	assign sof_run = host_q && con_bit0_q && power_q && !suspend_q;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sof_cnt_q <= '0;
			sof_q     <= 1'b0;
		end else if (!sof_run) begin
			sof_cnt_q <= '0;
			sof_q     <= 1'b0;
		end else if (sof_cnt_q == SOF_CNT_W'(SOF_CYCLES_P - 1)) begin
			sof_cnt_q <= '0;
			sof_q     <= 1'b1;
		end else begin
			sof_cnt_q <= sof_cnt_q + 1'b1;
			sof_q     <= 1'b0;
		end
	end

	// R22: read mux, unused bits zero except OTG bits 0, 1 and 3
	always_comb begin
		rd_mux = REG_RESET;
		unique case (reg_addr)
			OFS_POWER: begin
				rd_mux[ACT_PEND_BIT] = act_pend_q;
				rd_mux[GUARD_BIT]    = guard_q;
				rd_mux[SUSPEND_BIT]  = suspend_q;
				rd_mux[PWR_EN_BIT]   = power_q;
			end
			OFS_STATUS: begin
				rd_mux[STAT_EP_LSB +: 4] = stat_ep_q;
				rd_mux[STAT_DIR_BIT]     = stat_dir_q;
				rd_mux[STAT_BANK_BIT]    = stat_bank_q;
			end
			OFS_CONTROL: begin
				rd_mux[CON_J_STATE_LIVE_BIT] = host_q && j_live;
				rd_mux[CON_SE0_BIT]    = se0_live;
				rd_mux[CON_BIT5]       = host_q ? token_busy : pkt_dis_q;
				rd_mux[CON_BUSRST_BIT] = bus_rst_q;
				rd_mux[CON_HOST_BIT]   = host_q;
				rd_mux[CON_RESUME_BIT] = resume_q;
				rd_mux[CON_PPRST_BIT]  = pp_rst_q;
				rd_mux[CON_BIT0]       = con_bit0_q;
			end
			OFS_DEV_ADDR: begin
				// R18: speed bit zero in device mode
				rd_mux[7:0] = {ls_q && host_q, addr_q};
			end
			OFS_TOKEN: begin
				rd_mux[7:0] = {tok_pid_q, tok_ep_q};
			end
			OFS_OTG_CTRL: begin
				rd_mux[7:0] = otg_q;
			end
			default: begin
				rd_mux = REG_RESET;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rdata_q <= REG_RESET;
		end else if (reg_rd) begin
			rdata_q <= rd_mux;
		end else begin
			rdata_q <= REG_RESET;
		end
	end

	assign reg_rdata      = rdata_q;
	assign module_enable  = power_q;
	// R3: clock gate and low power
	assign usb_clock_run  = power_q && !suspend_q;
	assign xcvr_low_power = suspend_q;
	// R9: processing halt
	assign packet_proc_enable = !(pkt_dis_q && !host_q);
	// R12: even bank force
	assign ping_pong_reset = pp_rst_q;
	// R13: resume signaling
	assign resume_drive    = resume_q;
	// R16: bus reset
	assign bus_reset_drive = host_q && bus_rst_q;
	// R18: speed select
	assign low_speed_select = host_q && ls_q;
	// R10: R11: R23: pull resistor steering
	assign dp_pullup   = otg_q[OTG_EN_BIT] ? otg_q[OTG_DPPU_BIT] : (con_bit0_q && !host_q);
	assign dm_pullup   = otg_q[OTG_EN_BIT] && otg_q[OTG_DMPU_BIT];
	assign dp_pulldown = otg_q[OTG_EN_BIT] ? otg_q[OTG_DPPD_BIT] : host_q;
	assign dm_pulldown = otg_q[OTG_EN_BIT] ? otg_q[OTG_DMPD_BIT] : host_q;
	assign sof_send       = sof_q;
	assign token_launch   = launch_q;
	// R20: token type code out
	assign token_pid      = tok_pid_q;
	assign token_endpoint = tok_ep_q;
	assign device_address = addr_q;

	property p_act_pend;
		@(posedge clock) disable iff (!rst_b)
		!guard_q |=> !act_pend_q;
	endproperty
	a_act_pend: assert property (p_act_pend) else $error("pending without guard"); // R1

	property p_clock_gate;
		@(posedge clock) disable iff (!rst_b)
		suspend_q |-> !usb_clock_run && xcvr_low_power;
	endproperty
	a_clock_gate: assert property (p_clock_gate) else $error("clock runs in suspend"); // R3

	property p_stat_ep;
		@(posedge clock) disable iff (!rst_b)
		xfer_done |=> stat_ep_q == $past(xfer_ep) && stat_dir_q == $past(xfer_tx);
	endproperty
	a_stat_ep: assert property (p_stat_ep) else $error("status not captured"); // R5

	property p_setup_halt;
		@(posedge clock) disable iff (!rst_b)
		setup_rx && !host_q |=> !packet_proc_enable;
	endproperty
	a_setup_halt: assert property (p_setup_halt) else $error("SETUP did not halt"); // R9

	property p_host_pulls;
		@(posedge clock) disable iff (!rst_b)
		host_q && !otg_q[OTG_EN_BIT] |-> dp_pulldown && dm_pulldown && !dp_pullup;
	endproperty
	a_host_pulls: assert property (p_host_pulls) else $error("host pulls wrong"); // R10

	property p_tok_launch;
		@(posedge clock) disable iff (!rst_b)
		tok_start |=> token_launch && token_busy ##1 !token_launch;
	endproperty
	a_tok_launch: assert property (p_tok_launch) else $error("token not launched"); // R24

	property p_sof_period;
		@(posedge clock) disable iff (!rst_b)
		sof_send |-> $past(sof_cnt_q) == SOF_CNT_W'(SOF_CYCLES_P - 1) && $past(sof_run);
	endproperty
	a_sof_period: assert property (p_sof_period) else $error("frame start mistimed"); // R17

	property p_addr_wr;
		@(posedge clock) disable iff (!rst_b)
		wr_hit(OFS_DEV_ADDR) |=> device_address == $past(reg_wdata[6:0]);
	endproperty
	a_addr_wr: assert property (p_addr_wr) else $error("address not stored"); // R19

	property p_upper_zero;
		@(posedge clock) disable iff (!rst_b)
		reg_rd |=> reg_rdata[15:8] == 8'h00;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper byte nonzero"); // R22

endmodule : usb_core_ctl
`default_nettype wire

/* verif/usb_far_end.sv */
`timescale 1ns/100ps
`default_nettype none
module usb_far_end #(
	parameter int unsigned DONE_DLY = 6
) (
	input  wire logic       clock,
	input  wire logic       rst_b,
	input  wire logic       token_launch,
	output logic            token_done,
	output logic            line_dp,
	output logic            line_dm,
	output logic            sie_busy,
	output logic            wake_event,
	output logic            setup_rx,
	output logic            xfer_done,
	output logic      [3:0] xfer_ep,
	output logic            xfer_tx,
	output logic            xfer_odd
);
	int unsigned run_cnt = 0;
	initial begin
		{wake_event, setup_rx, xfer_done, sie_busy} = '0;
		{line_dp, line_dm} = 2'b10;
		{xfer_ep, xfer_tx, xfer_odd} = 6'h0;
	end
	// answer each launched token after a delay
	always @(posedge clock) begin
		token_done <= 1'b0;
		if (!rst_b) run_cnt <= 0;
		else if (token_launch === 1'b1) run_cnt <= DONE_DLY;
		else if (run_cnt == 1) begin
			token_done <= 1'b1;
			run_cnt <= 0;
		end else if (run_cnt != 0) run_cnt <= run_cnt - 1;
	end
	task automatic line(input logic dp, input logic dm);
		@(posedge clock);
		line_dp <= dp;
		line_dm <= dm;
	endtask : line
	task automatic busy(input logic b);
		@(posedge clock);
		sie_busy <= b;
	endtask : busy
	task automatic wake();
		@(posedge clock);
		wake_event <= 1'b1;
		@(posedge clock);
		wake_event <= 1'b0;
	endtask : wake
	task automatic setup();
		@(posedge clock);
		setup_rx <= 1'b1;
		@(posedge clock);
		setup_rx <= 1'b0;
	endtask : setup
	// one completed transfer, fields invalid after
	task automatic xfer(input logic [3:0] ep, input logic tx, input logic odd);
		@(posedge clock);
		{xfer_done, xfer_ep, xfer_tx, xfer_odd} <= {1'b1, ep, tx, odd};
		@(posedge clock);
		{xfer_done, xfer_ep, xfer_tx, xfer_odd} <= {1'b0, ~ep, ~tx, ~odd};
	endtask : xfer
endmodule : usb_far_end
`default_nettype wire

/* verif/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
	import usb_ctl_pkg::*;
	localparam int unsigned SOF_N = 20;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [DATA_W-1:0] reg_rdata;
	logic line_dp, line_dm, sie_busy, wake_event, setup_rx;
	logic xfer_done, xfer_tx, xfer_odd, token_done;
	logic [3:0] xfer_ep, token_pid, token_endpoint;
	logic module_enable, usb_clock_run, xcvr_low_power, packet_proc_enable;
	logic ping_pong_reset, resume_drive, bus_reset_drive, low_speed_select;
	logic dp_pullup, dm_pullup, dp_pulldown, dm_pulldown, sof_send, token_launch;
	logic [6:0] device_address;
	logic [3:0] pulls;
	int n_fail = 0;
	int checks_done = 0;
	int sofs;
	logic [3:0] pid_list [3] = '{PID_SETUP, PID_IN, PID_OUT};
	logic [3:0] ep_list [3] = '{4'h0, 4'h7, 4'hf};
	assign pulls = {dp_pullup, dm_pullup, dp_pulldown, dm_pulldown};
	always #5 clock = ~clock;
	usb_core_ctl #(.SOF_CYCLES_P(SOF_N)) dut_u (.clock(clock), .rst_b(rst_b),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .line_dp(line_dp), .line_dm(line_dm),
		.sie_busy(sie_busy), .wake_event(wake_event), .setup_rx(setup_rx),
		.xfer_done(xfer_done), .xfer_ep(xfer_ep), .xfer_tx(xfer_tx),
		.xfer_odd(xfer_odd), .token_done(token_done), .module_enable(module_enable),
		.usb_clock_run(usb_clock_run), .xcvr_low_power(xcvr_low_power),
		.packet_proc_enable(packet_proc_enable), .ping_pong_reset(ping_pong_reset),
		.resume_drive(resume_drive), .bus_reset_drive(bus_reset_drive),
		.low_speed_select(low_speed_select), .dp_pullup(dp_pullup),
		.dm_pullup(dm_pullup), .dp_pulldown(dp_pulldown), .dm_pulldown(dm_pulldown),
		.sof_send(sof_send), .token_launch(token_launch), .token_pid(token_pid),
		.token_endpoint(token_endpoint), .device_address(device_address));
	usb_far_end #(.DONE_DLY(6)) far_u (.clock(clock), .rst_b(rst_b),
		.token_launch(token_launch), .token_done(token_done), .line_dp(line_dp),
		.line_dm(line_dm), .sie_busy(sie_busy), .wake_event(wake_event),
		.setup_rx(setup_rx), .xfer_done(xfer_done), .xfer_ep(xfer_ep),
		.xfer_tx(xfer_tx), .xfer_odd(xfer_odd));
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value at %0t: got %h, expected %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge clock);
		reg_wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clock);
		{reg_rd, reg_addr} <= {1'b1, a};
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask : rd
	task automatic count_sof(input int n);
		sofs = 0;
		repeat (n) begin
			@(posedge clock);
			#1 if (sof_send === 1'b1) sofs++;
		end
	endtask : count_sof
	task automatic close_out();
		$display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : close_out
	initial begin
		#200000;
		n_fail++;
		close_out();
	end
	initial begin
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		#1 chk(16'(packet_proc_enable), 16'h1);
		wr(4'hc, 16'hffff);
		for (int a = 0; a < 16; a += 2) rd(4'(a), 16'h0);
		wr(OFS_POWER, 16'hffff);
		rd(OFS_POWER, 16'h0013);
		chk(16'({usb_clock_run, xcvr_low_power, module_enable}), 16'h3);
		far_u.busy(1'b1);
		rd(OFS_POWER, 16'h0093);
		far_u.wake();
		far_u.busy(1'b0);
		rd(OFS_POWER, 16'h0011);
		chk(16'({usb_clock_run, xcvr_low_power}), 16'h2);
		far_u.xfer(4'hf, 1'b1, 1'b1);
		rd(OFS_STATUS, 16'h00fc);
		far_u.xfer(4'h0, 1'b0, 1'b0);
		rd(OFS_STATUS, 16'h0000);
		wr(OFS_CONTROL, 16'h0001);
		chk(16'(pulls), 16'h8);
		far_u.setup();
		#1 chk(16'(packet_proc_enable), 16'h0);
		rd(OFS_CONTROL, 16'h0021);
		wr(OFS_CONTROL, 16'h0007);
		chk(16'({packet_proc_enable, ping_pong_reset, resume_drive}), 16'h7);
		far_u.line(1'b0, 1'b0);
		repeat (3) @(posedge clock);
		rd(OFS_CONTROL, 16'h0047);
		far_u.line(1'b1, 1'b0);
		wr(OFS_DEV_ADDR, 16'h00ff);
		rd(OFS_DEV_ADDR, 16'h007f);
		chk(16'({low_speed_select, device_address}), 16'h007f);
		wr(OFS_CONTROL, 16'h0018);
		chk(16'({pulls, bus_reset_drive}), 16'h7);
		wr(OFS_DEV_ADDR, 16'h007f);
		rd(OFS_CONTROL, 16'h0098);
		wr(OFS_CONTROL, 16'h0008);
		chk(16'(bus_reset_drive), 16'h0);
		wr(OFS_DEV_ADDR, 16'h00ff);
		chk(16'(low_speed_select), 16'h1);
		far_u.line(1'b0, 1'b1);
		repeat (3) @(posedge clock);
		rd(OFS_CONTROL, 16'h0088);
		wr(OFS_DEV_ADDR, 16'h0005);
		far_u.line(1'b1, 1'b0);
		wr(OFS_CONTROL, 16'h0009);
		count_sof(3 * SOF_N);
		chk(16'(sofs), 16'h3);
		wr(OFS_CONTROL, 16'h0008);
		count_sof(3 * SOF_N);
		chk(16'(sofs), 16'h0);
		for (int i = 0; i < 3; i++) begin
			wr(OFS_TOKEN, {8'h00, pid_list[i], ep_list[i]});
			chk(16'({token_launch, token_pid, token_endpoint}), {7'h0, 1'b1, pid_list[i], ep_list[i]});
			rd(OFS_CONTROL, 16'h00a8);
			repeat (8) @(posedge clock);
			rd(OFS_CONTROL, 16'h0088);
			rd(OFS_TOKEN, {8'h00, pid_list[i], ep_list[i]});
		end
		wr(OFS_TOKEN, 16'h0053);
		chk(16'(token_launch), 16'h0);
		rd(OFS_CONTROL, 16'h0088);
		wr(OFS_OTG_CTRL, 16'h0054);
		chk(16'(pulls), 16'h5);
		rd(OFS_OTG_CTRL, 16'h0054);
		close_out();
	end
endmodule : tb
`default_nettype wire
